// [bench/ldo_regs_properties.sv]
`timescale 1ns/1ps
// port-level checks on the regulator register bank
module ldo_regs_checker (
    input wire clock,
    input wire reset_n,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [11:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire [3:0] regulator_on,
    input wire [3:0] discharge_req,
    input wire [5:0] ldo6_output_level_code,
    input wire fault_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    reg [3:0] flt_en_r;
    reg [3:0] irq_en_r;
    wire wr_beat = wb_ack_o && wb_we_i && wb_sel_i[0];
    // mirror of both interrupt gates, kept from accepted writes
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            flt_en_r <= 4'h0;
            irq_en_r <= 4'hf;
        end else if (wr_beat) begin
            case (wb_adr_i)
                12'h164: flt_en_r[0] <= wb_dat_i[1];
                12'h184: flt_en_r[1] <= wb_dat_i[1];
                12'h1a4: flt_en_r[2] <= wb_dat_i[1];
                12'h1c4: flt_en_r[3] <= wb_dat_i[1];
                12'h244: irq_en_r <= wb_dat_i[3:0];
                default: ;
            endcase
        end
    end
    // accepted write and read beats at one address
    sequence s_wr(a);
        wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == a;
    endsequence
    sequence s_rd(a);
        wb_ack_o && !wb_we_i && wb_adr_i == a;
    endsequence
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    a_level_write: assert property (
        s_wr(12'h180) |=> ldo6_output_level_code == $past(wb_dat_i[5:0]))
        else $error("level code not taken from write");
    a_level_hold: assert property (
        $changed(ldo6_output_level_code) |-> $past(wb_ack_o && wb_we_i && wb_adr_i == 12'h180))
        else $error("level code changed without write");
    a_on_write: assert property (
        s_wr(12'h184) |=> regulator_on[1] == $past(wb_dat_i[7]))
        else $error("enable bit not taken from write");
    a_on_hold: assert property (
        $changed(regulator_on) |-> $past(wb_ack_o && wb_we_i))
        else $error("enable changed without write");
    a_dis_when_off: assert property ((discharge_req & $past(regulator_on)) == 4'h0)
        else $error("discharge while regulator on");
    a_dis_needs_write: assert property (
        (discharge_req & ~$past(discharge_req)) != 4'h0 |-> $past(wb_ack_o && wb_we_i, 2))
        else $error("discharge rose without write");
    a_irq_gated: assert property (fault_irq |-> $past(|(flt_en_r & irq_en_r)))
        else $error("fault interrupt with no source enabled");
    a_ctl_reserved: assert property (
        s_rd(12'h184) |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[6:3] == 4'h0)
        else $error("reserved control bits not zero");
endmodule // ldo_regs_checker

bind ldo_regs ldo_regs_checker u_chk (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .regulator_on(regulator_on), .discharge_req(discharge_req),
    .ldo6_output_level_code(ldo6_output_level_code), .fault_irq(fault_irq));

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
    reg clock, reset_n, wb_cyc_i, wb_stb_i, wb_we_i;
    reg [11:0] wb_adr_i;
    reg [3:0] wb_sel_i, power_good_in, fault_in;
    reg [31:0] wb_dat_i, rd;
    wire [31:0] wb_dat_o;
    wire wb_ack_o, fault_irq;
    wire [3:0] regulator_on, discharge_req;
    wire [5:0] lv6, lv7, lv8, lv9;
    integer mismatches = 0, check_count = 0, cycles = 0, i;
    ldo_regs dut (.clock(clock), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .power_good_in(power_good_in),
        .fault_in(fault_in), .regulator_on(regulator_on), .discharge_req(discharge_req),
        .ldo6_output_level_code(lv6), .ldo7_output_level_code(lv7),
        .ldo8_output_level_code(lv8), .ldo9_output_level_code(lv9), .fault_irq(fault_irq));
    // 25 ns clock
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            complete_run;
        end
    end
    // byte addresses of level and control registers, ldo9 level sits apart
    function [11:0] lvl(input integer n);
        lvl = (n == 3) ? 12'h200 : 12'h180 + 12'h20 * n[11:0];
    endfunction
    function [11:0] ctl(input integer n);
        ctl = 12'h164 + 12'h20 * n[11:0];
    endfunction
    task complete_run;
        if (mismatches == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task chk_data(input [31:0] got, input [31:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t data %h expected %h", $time, got, exp);
        end
    endtask
    task chk_pin(input [23:0] got, input [23:0] exp);
        check_count = check_count + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t pins %h expected %h", $time, got, exp);
        end
    endtask
    // one classic cycle; ack and read data are taken at the same edge
    task bus(input w, input [11:0] a, input [31:0] d, output [31:0] q);
        @(posedge clock);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        wb_sel_i <= 4'h1;
        @(posedge clock);
        while (wb_ack_o !== 1'b1) @(posedge clock);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task rd_chk(input [11:0] a, input [31:0] exp);
        bus(1'b0, a, 32'h0, rd);
        chk_data(rd, exp);
    endtask
    // main sequence
    initial begin
        reset_n = 1'b0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = 0;
        power_good_in = 4'h0;
        fault_in = 4'h0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            rd_chk(lvl(i), 32'h0);
            rd_chk(ctl(i), 32'h0);
            bus(1'b1, lvl(i), 32'hffffffff, rd);
            rd_chk(lvl(i), 32'h3f);
            bus(1'b1, lvl(i), 32'h10 + i, rd);
            bus(1'b1, ctl(i), 32'hff, rd);
            rd_chk(ctl(i), 32'h86);
        end
        rd_chk(12'h244, 32'hf);
        chk_pin({lv9, lv8, lv7, lv6}, {6'h13, 6'h12, 6'h11, 6'h10});
        repeat (3) @(posedge clock);
        chk_pin({20'h0, regulator_on}, 24'hf);
        chk_pin({20'h0, discharge_req}, 24'h0);
        // off with discharge enabled, then discharge disabled both on and off
        for (i = 0; i < 4; i = i + 1) bus(1'b1, ctl(i), 32'h04, rd);
        repeat (3) @(posedge clock);
        chk_pin({20'h0, regulator_on}, 24'h0);
        chk_pin({20'h0, discharge_req}, 24'hf);
        for (i = 0; i < 4; i = i + 1) bus(1'b1, ctl(i), {24'h0, i[0], 7'h0}, rd);
        repeat (3) @(posedge clock);
        chk_pin({20'h0, regulator_on}, 24'ha);
        chk_pin({20'h0, discharge_req}, 24'h0);
        // power good passes a synchroniser before it reads back
        power_good_in <= 4'h5;
        repeat (8) @(posedge clock);
        for (i = 0; i < 4; i = i + 1) rd_chk(ctl(i), {24'h0, i[0], 6'h0, ~i[0]});
        rd_chk(12'h24c, 32'h05);
        // ldo5 may interrupt, ldo6 may not
        bus(1'b1, ctl(0), 32'h02, rd);
        bus(1'b1, ctl(1), 32'h00, rd);
        fault_in <= 4'h2;
        repeat (8) @(posedge clock);
        chk_pin({23'h0, fault_irq}, 24'h0);
        rd_chk(12'h240, 32'h2);
        fault_in <= 4'h1;
        repeat (8) @(posedge clock);
        chk_pin({23'h0, fault_irq}, 24'h1);
        bus(1'b1, 12'h244, 32'h0, rd);
        repeat (3) @(posedge clock);
        chk_pin({23'h0, fault_irq}, 24'h0);
        bus(1'b1, 12'h244, 32'hf, rd);
        repeat (3) @(posedge clock);
        chk_pin({23'h0, fault_irq}, 24'h1);
        fault_in <= 4'h0;
        repeat (8) @(posedge clock);
        bus(1'b1, 12'h248, 32'hf, rd);
        repeat (3) @(posedge clock);
        chk_pin({23'h0, fault_irq}, 24'h0);
        rd_chk(12'h240, 32'h0);
        // unmapped and misaligned places read zero
        bus(1'b1, 12'h3fc, 32'hff, rd);
        rd_chk(12'h3fc, 32'h0);
        rd_chk(12'h185, 32'h0);
        // a misaligned write must leave the ldo6 level alone
        bus(1'b1, 12'h181, 32'h2a, rd);
        chk_pin({18'h0, lv6}, 24'h10);
        complete_run;
    end
endmodule // tb

// [include/ldo_defines.vh]
`ifndef LDO_DEFINES_VH
`define LDO_DEFINES_VH

// register indices; byte address is four times the index
`define LDO_IDX_LDO5_CONTROL 8'h59
`define LDO_IDX_LDO6_LEVEL 8'h60
`define LDO_IDX_LDO6_CONTROL 8'h61
`define LDO_IDX_LDO7_LEVEL 8'h68
`define LDO_IDX_LDO7_CONTROL 8'h69
`define LDO_IDX_LDO8_LEVEL 8'h70
`define LDO_IDX_LDO8_CONTROL 8'h71
`define LDO_IDX_LDO9_LEVEL 8'h80
// interrupt and pin-state registers
`define LDO_IDX_IRQ_STATUS 8'h90
`define LDO_IDX_IRQ_ENABLE 8'h91
`define LDO_IDX_IRQ_CLEAR 8'h92
`define LDO_IDX_PIN_STATE 8'h93

// field positions
`define LDO_LEVEL_MSB 5
`define LDO_CTL_ON_BIT 7
`define LDO_CTL_DIS_BIT 2
`define LDO_CTL_FLT_BIT 1
`define LDO_CTL_PG_BIT 0

// widths and reset values
`define LDO_NREG 4
`define LDO_LEVEL_RST 6'h00
`define LDO_CTL_RST 3'h0
`define LDO_IRQ_EN_RST 4'hf

`endif

// [rtl/ldo_irq.v]
`timescale 1ns/1ps
`include "ldo_defines.vh"

module ldo_irq (
    clock,
    reset_n,
    event_in,
    source_gate,
    clear_we,
    enable_we,
    wr_data,
    status_r,
    enable_r,
    irq_r
);
    input wire clock;
    input wire reset_n;
    input wire [`LDO_NREG-1:0] event_in;
    input wire [`LDO_NREG-1:0] source_gate;
    input wire clear_we;
    input wire enable_we;
    input wire [`LDO_NREG-1:0] wr_data;
    output reg [`LDO_NREG-1:0] status_r;
    output reg [`LDO_NREG-1:0] enable_r;
    output reg irq_r;

    reg [`LDO_NREG-1:0] status_nxt;

    // set beats clear so a fault in the clearing cycle survives
    always @* begin
        status_nxt = status_r;
        if (clear_we) begin
            status_nxt = status_nxt & ~wr_data;
        end
        status_nxt = status_nxt | event_in;
    end

    // sticky status, enable mask, registered level interrupt
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_r <= {`LDO_NREG{1'b0}};
            enable_r <= `LDO_IRQ_EN_RST;
            irq_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            if (enable_we) begin
                enable_r <= wr_data;
            end
            irq_r <= |(status_r & enable_r & source_gate);
        end
    end
endmodule // ldo_irq

// [rtl/ldo_regs.v]
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`include "ldo_defines.vh"

// How it works
// - each level register keeps a six-bit read/write voltage code in bits 5..0.
// - control bit 7 written one turns the regulator on; reads back as written.
// - control bit 7 written zero turns the regulator off into shutdown.
// - discharge request asserted while bit 2 is one and regulator is off.
// - discharge request never asserted while bit 2 is zero.
// - with bit 1 set and its interrupt enable bit set, a regulator fault raises the fault interrupt.
// - with bit 1 clear, that regulator's faults never raise the interrupt.
// - bit 0 reads live power-good state; writes to it do nothing.
module ldo_regs (
    clock,
    reset_n,
    wb_cyc_i,
    wb_stb_i,
    wb_we_i,
    wb_adr_i,
    wb_sel_i,
    wb_dat_i,
    wb_dat_o,
    wb_ack_o,
    power_good_in,
    fault_in,
    regulator_on,
    discharge_req,
    ldo6_output_level_code,
    ldo7_output_level_code,
    ldo8_output_level_code,
    ldo9_output_level_code,
    fault_irq
);
    input wire clock;
    input wire reset_n;
    input wire wb_cyc_i;
    input wire wb_stb_i;
    input wire wb_we_i;
    input wire [11:0] wb_adr_i;
    input wire [3:0] wb_sel_i;
    input wire [31:0] wb_dat_i;
    output reg [31:0] wb_dat_o;
    output reg wb_ack_o;
    input wire [`LDO_NREG-1:0] power_good_in;
    input wire [`LDO_NREG-1:0] fault_in;
    output wire [`LDO_NREG-1:0] regulator_on;
    output reg [`LDO_NREG-1:0] discharge_req;
    output wire [5:0] ldo6_output_level_code;
    output wire [5:0] ldo7_output_level_code;
    output wire [5:0] ldo8_output_level_code;
    output wire [5:0] ldo9_output_level_code;
    output wire fault_irq;

    // per-regulator control bits; index 0 is ldo5, 3 is ldo8
    reg [`LDO_NREG-1:0] on_r;
    reg [`LDO_NREG-1:0] shutdown_discharge_enable_r;
    reg [`LDO_NREG-1:0] fault_irq_enable_r;
    // level codes; index 0 is ldo6, 3 is ldo9
    reg [5:0] level6_r;
    reg [5:0] level7_r;
    reg [5:0] level8_r;
    reg [5:0] level9_r;

    reg [`LDO_NREG-1:0] fault_prev_r;
    reg [31:0] rd_data;

    wire [`LDO_NREG-1:0] pgood_s;
    wire [`LDO_NREG-1:0] fault_s;
    wire [`LDO_NREG-1:0] fault_rise;
    wire [`LDO_NREG-1:0] irq_status;
    wire [`LDO_NREG-1:0] irq_enable;
    wire bus_req;
    wire in_window;
    wire [7:0] reg_idx;
    wire wr_commit;
    wire wr_lane0;
    wire [`LDO_NREG-1:0] ctl_wr;
    wire irq_clear_we;
    wire irq_enable_we;

    // pack one control byte; unused bits read zero
    function [7:0] ctl_byte;
        input on_bit;
        input dis_bit;
        input flt_bit;
        input pg_bit;
        begin
            ctl_byte = 8'h00;
            ctl_byte[`LDO_CTL_ON_BIT] = on_bit;
            ctl_byte[`LDO_CTL_DIS_BIT] = dis_bit;
            ctl_byte[`LDO_CTL_FLT_BIT] = flt_bit;
            ctl_byte[`LDO_CTL_PG_BIT] = pg_bit;
        end
    endfunction

    // true when a committed lane-0 write hits the given index
    function wr_hit;
        input [7:0] idx;
        input [7:0] target;
        input commit;
        begin
            wr_hit = commit && (idx == target);
        end
    endfunction

    // comparator and fault pins come from the analog side
    // about four edges from pin to register: three stages, then agreement
    ldo_sync3 u_pg_sync (
        .clock(clock),
        .reset_n(reset_n),
        .pin_in(power_good_in),
        .level_out(pgood_s)
    );

    ldo_sync3 u_fault_sync (
        .clock(clock),
        .reset_n(reset_n),
        .pin_in(fault_in),
        .level_out(fault_s)
    );

    // bus decode: aligned words only, upper address bits must be zero
    assign bus_req = wb_cyc_i & wb_stb_i;
    assign in_window = (wb_adr_i[11:10] == 2'b00) && (wb_adr_i[1:0] == 2'b00);
    // byte address is four times the index, so bits 9..2 pick the register
    assign reg_idx = wb_adr_i[9:2];
    // write lands on the edge where the master sees ack
    assign wr_commit = bus_req & wb_we_i & wb_ack_o & in_window;
    assign wr_lane0 = wr_commit & wb_sel_i[0];

    // per-regulator control strobes, ldo5 first
    assign ctl_wr[0] = wr_hit(reg_idx, `LDO_IDX_LDO5_CONTROL, wr_lane0);
    assign ctl_wr[1] = wr_hit(reg_idx, `LDO_IDX_LDO6_CONTROL, wr_lane0);
    assign ctl_wr[2] = wr_hit(reg_idx, `LDO_IDX_LDO7_CONTROL, wr_lane0);
    assign ctl_wr[3] = wr_hit(reg_idx, `LDO_IDX_LDO8_CONTROL, wr_lane0);
    // interrupt register strobes, committed with the same timing
    assign irq_clear_we = wr_hit(reg_idx, `LDO_IDX_IRQ_CLEAR, wr_lane0);
    assign irq_enable_we = wr_hit(reg_idx, `LDO_IDX_IRQ_ENABLE, wr_lane0);

    // one wait state then ack, dropped the cycle after
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_req & ~wb_ack_o;
        end
    end

    // control registers
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            on_r <= {`LDO_NREG{1'b0}};
            shutdown_discharge_enable_r <= {`LDO_NREG{1'b0}};
            fault_irq_enable_r <= {`LDO_NREG{1'b0}};
        end else begin
            if (ctl_wr[0]) begin
                on_r[0] <= wb_dat_i[`LDO_CTL_ON_BIT];
                shutdown_discharge_enable_r[0] <= wb_dat_i[`LDO_CTL_DIS_BIT];
                fault_irq_enable_r[0] <= wb_dat_i[`LDO_CTL_FLT_BIT];
            end
            if (ctl_wr[1]) begin
                on_r[1] <= wb_dat_i[`LDO_CTL_ON_BIT];
                shutdown_discharge_enable_r[1] <= wb_dat_i[`LDO_CTL_DIS_BIT];
                fault_irq_enable_r[1] <= wb_dat_i[`LDO_CTL_FLT_BIT];
            end
            if (ctl_wr[2]) begin
                on_r[2] <= wb_dat_i[`LDO_CTL_ON_BIT];
                shutdown_discharge_enable_r[2] <= wb_dat_i[`LDO_CTL_DIS_BIT];
                fault_irq_enable_r[2] <= wb_dat_i[`LDO_CTL_FLT_BIT];
            end
            if (ctl_wr[3]) begin
                on_r[3] <= wb_dat_i[`LDO_CTL_ON_BIT];
                shutdown_discharge_enable_r[3] <= wb_dat_i[`LDO_CTL_DIS_BIT];
                fault_irq_enable_r[3] <= wb_dat_i[`LDO_CTL_FLT_BIT];
            end
        end
    end

    // level registers; bits 7..6 are dropped on write
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            level6_r <= `LDO_LEVEL_RST;
            level7_r <= `LDO_LEVEL_RST;
            level8_r <= `LDO_LEVEL_RST;
            level9_r <= `LDO_LEVEL_RST;
        end else begin
            if (wr_hit(reg_idx, `LDO_IDX_LDO6_LEVEL, wr_lane0)) begin
                level6_r <= wb_dat_i[`LDO_LEVEL_MSB:0];
            end
            if (wr_hit(reg_idx, `LDO_IDX_LDO7_LEVEL, wr_lane0)) begin
                level7_r <= wb_dat_i[`LDO_LEVEL_MSB:0];
            end
            if (wr_hit(reg_idx, `LDO_IDX_LDO8_LEVEL, wr_lane0)) begin
                level8_r <= wb_dat_i[`LDO_LEVEL_MSB:0];
            end
            if (wr_hit(reg_idx, `LDO_IDX_LDO9_LEVEL, wr_lane0)) begin
                level9_r <= wb_dat_i[`LDO_LEVEL_MSB:0];
            end
        end
    end

    assign regulator_on = on_r;
    assign ldo6_output_level_code = level6_r;
    assign ldo7_output_level_code = level7_r;
    assign ldo8_output_level_code = level8_r;
    assign ldo9_output_level_code = level9_r;

    // discharge only in shutdown and only when allowed
    // a write that turns a regulator off starts discharge one cycle later
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            discharge_req <= {`LDO_NREG{1'b0}};
        end else begin
            discharge_req <= shutdown_discharge_enable_r & ~on_r;
        end
    end

    // fault edges; a held fault counts once
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fault_prev_r <= {`LDO_NREG{1'b0}};
        end else begin
            fault_prev_r <= fault_s;
        end
    end

    assign fault_rise = fault_s & ~fault_prev_r;

    ldo_irq u_irq (
        .clock(clock),
        .reset_n(reset_n),
        .event_in(fault_rise),
        .source_gate(fault_irq_enable_r),
        .clear_we(irq_clear_we),
        .enable_we(irq_enable_we),
        .wr_data(wb_dat_i[`LDO_NREG-1:0]),
        .status_r(irq_status),
        .enable_r(irq_enable),
        .irq_r(fault_irq)
    );

    // read mux; unmapped and write-only indices read zero
    always @* begin
        rd_data = 32'h0000_0000;
        if (in_window) begin
            case (reg_idx)
                `LDO_IDX_LDO5_CONTROL: begin
                    rd_data[7:0] = ctl_byte(on_r[0], shutdown_discharge_enable_r[0],
                        fault_irq_enable_r[0], pgood_s[0]);
                end
                `LDO_IDX_LDO6_CONTROL: begin
                    rd_data[7:0] = ctl_byte(on_r[1], shutdown_discharge_enable_r[1],
                        fault_irq_enable_r[1], pgood_s[1]);
                end
                `LDO_IDX_LDO7_CONTROL: begin
                    rd_data[7:0] = ctl_byte(on_r[2], shutdown_discharge_enable_r[2],
                        fault_irq_enable_r[2], pgood_s[2]);
                end
                `LDO_IDX_LDO8_CONTROL: begin
                    rd_data[7:0] = ctl_byte(on_r[3], shutdown_discharge_enable_r[3],
                        fault_irq_enable_r[3], pgood_s[3]);
                end
                `LDO_IDX_LDO6_LEVEL: begin
                    rd_data[5:0] = level6_r;
                end
                `LDO_IDX_LDO7_LEVEL: begin
                    rd_data[5:0] = level7_r;
                end
                `LDO_IDX_LDO8_LEVEL: begin
                    rd_data[5:0] = level8_r;
                end
                `LDO_IDX_LDO9_LEVEL: begin
                    rd_data[5:0] = level9_r;
                end
                `LDO_IDX_IRQ_STATUS: begin
                    rd_data[`LDO_NREG-1:0] = irq_status;
                end
                `LDO_IDX_IRQ_ENABLE: begin
                    rd_data[`LDO_NREG-1:0] = irq_enable;
                end
                `LDO_IDX_PIN_STATE: begin
                    rd_data[7:0] = {fault_s, pgood_s};
                end
                default: begin
                    rd_data = 32'h0000_0000;
                end
            endcase
        end
    end

    // read data captured at request, held through ack
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (bus_req & ~wb_ack_o) begin
            wb_dat_o <= rd_data;
        end
    end
endmodule // ldo_regs

// [rtl/ldo_sync3.v]
`timescale 1ns/1ps
`include "ldo_defines.vh"

module ldo_sync3 (
    clock,
    reset_n,
    pin_in,
    level_out
);
    input wire clock;
    input wire reset_n;
    input wire [`LDO_NREG-1:0] pin_in;
    output reg [`LDO_NREG-1:0] level_out;

    reg [`LDO_NREG-1:0] meta_r;
    reg [`LDO_NREG-1:0] s2_r;
    reg [`LDO_NREG-1:0] s3_r;
    integer i;

    // three-stage chain; first stage feeds only the second
    always @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= {`LDO_NREG{1'b0}};
            s2_r <= {`LDO_NREG{1'b0}};
            s3_r <= {`LDO_NREG{1'b0}};
            level_out <= {`LDO_NREG{1'b0}};
        end else begin
            meta_r <= pin_in;
            s2_r <= meta_r;
            s3_r <= s2_r;
            // accept a change only once stages two and three agree
            for (i = 0; i < `LDO_NREG; i = i + 1) begin
                if (s2_r[i] == s3_r[i]) begin
                    level_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule // ldo_sync3
